// *** hdl/adcc_pkg.sv ***
package adcc_pkg;

  // register byte addresses on apb
  localparam logic [7:0] ADCC_OFS_INPUT_SEL   = 8'h00;
  localparam logic [7:0] ADCC_OFS_CTRL_STAT   = 8'h04;
  localparam logic [7:0] ADCC_OFS_RESULT_LOW  = 8'h08;
  localparam logic [7:0] ADCC_OFS_RESULT_HIGH = 8'h0c;
  localparam logic [7:0] ADCC_OFS_TRIG_SEL    = 8'h10;

  // control and status field positions
  localparam int ADCC_BIT_ON    = 7;
  localparam int ADCC_BIT_START = 6;
  localparam int ADCC_BIT_AUTO  = 5;
  localparam int ADCC_BIT_DONE  = 4;
  localparam int ADCC_BIT_IE    = 3;

  // input select field positions
  localparam int ADCC_BIT_LEFT  = 5;

  // reset values
  localparam logic [7:0] ADCC_RST_CTRL   = 8'h00;
  localparam logic [4:0] ADCC_RST_SEL    = 5'h00;
  localparam logic [9:0] ADCC_RST_RESULT = 10'h000;

  // channel codes
  localparam logic [4:0] ADCC_SEL_SE_LAST   = 5'h07;
  localparam logic [4:0] ADCC_SEL_DIFF_LAST = 5'h1d;
  localparam logic [4:0] ADCC_SEL_BANDGAP   = 5'h1e;
  localparam logic [4:0] ADCC_SEL_GROUND    = 5'h1f;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] ADCC_CYC_FIRST  = 5'h19;
  localparam logic [4:0] ADCC_CYC_NORMAL = 5'h0d;

  // trigger source code for free running
  localparam logic [2:0] ADCC_TRIG_FREE = 3'h0;

  typedef enum logic [1:0] {
    ADCC_GAIN_1X,
    ADCC_GAIN_10X,
    ADCC_GAIN_200X,
    ADCC_GAIN_NONE
  } adcc_gain_t;

  // request to the analog core
  typedef struct packed {
    logic       start;
    logic [2:0] pos_input;
    logic [2:0] neg_input;
    logic       differential;
    logic       bandgap;
    logic       ground;
    adcc_gain_t gain;
  } adcc_core_req_t;

endpackage

// *** hdl/adcc_prescaler.sv ***
`timescale 1ns/10ps
module adcc_prescaler
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] divider_select,
  // converter clock tick
  output logic            tick
);

  logic [6:0] count_ff;
  logic [6:0] terminal;
  logic       tick_ff;

  // codes 000 and 001 both divide by two
  always_comb begin
    case (divider_select)
      3'h0, 3'h1: terminal = 7'h01;
      3'h2:       terminal = 7'h03;
      3'h3:       terminal = 7'h07;
      3'h4:       terminal = 7'h0f;
      3'h5:       terminal = 7'h1f;
      3'h6:       terminal = 7'h3f;
      default:    terminal = 7'h7f;
    endcase
  end

  // free count held at zero while off; tick once per divided period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 7'h00;
      tick_ff  <= 1'b0;
    end else if (!run) begin
      count_ff <= 7'h00;
      tick_ff  <= 1'b0;
    end else begin
      tick_ff  <= (count_ff >= terminal);
      count_ff <= (count_ff >= terminal) ? 7'h00 : count_ff + 7'h01;
    end
  end

  assign tick = tick_ff;

endmodule // adcc_prescaler

// *** hdl/adcc_top.sv ***
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger and interrupt side
  input  wire logic        trigger_in,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  output logic             done_irq,
  // analog core
  output adcc_core_req_t   core_req,
  input  wire logic        core_done,
  input  wire logic [9:0]  core_result
);

  // registers
  logic [4:0]      channel_gain_select_ff;
  logic [4:0]      active_select_ff;
  logic            left_align_select_ff;
  logic            converter_on_ff;
  logic            auto_trigger_on_ff;
  logic            conversion_done_flag_ff;
  logic            done_irq_enable_ff;
  logic [2:0]      clock_divider_select_ff;
  logic [2:0]      trigger_source_select_ff;
  logic            busy_ff;
  logic            first_pending_ff;
  logic [4:0]      cycle_count_ff;
  logic [4:0]      cycle_target_ff;
  logic            start_req_ff;
  logic [9:0]      conversion_result_ff;
  logic            lock_ff;
  logic            trig_meta_ff;
  logic            trig_sync_ff;
  logic            trig_prev_ff;
  logic            source_level_prev_ff;
  logic [31:0]     prdata_ff;
  logic            pready_ff;
  logic            done_irq_ff;
  adcc_core_req_t  core_req_ff;
  adcc_core_req_t  nxt_core_req;

  // decode
  logic            wr_en;
  logic            rd_en;
  logic            wr_ctrl;
  logic            wr_sel;
  logic            wr_trig;
  logic            rd_low;
  logic            rd_high;
  logic            mapped;
  logic            sw_start;
  logic            trig_level;
  logic            trig_edge;
  logic            launch;
  logic            tick;
  logic            finish;
  logic            abort;
  logic [9:0]      nxt_stored;
  logic [7:0]      result_low;
  logic [7:0]      result_high;
  logic [7:0]      ctrl_read;
  logic            is_diff;

  // apb access phase; one wait state, the registered answer comes in the second access cycle
  assign wr_en   = psel && penable && pwrite && !pready_ff;
  assign rd_en   = psel && penable && !pwrite && !pready_ff;
  assign wr_ctrl = wr_en && (paddr == ADCC_OFS_CTRL_STAT);
  assign wr_sel  = wr_en && (paddr == ADCC_OFS_INPUT_SEL);
  assign wr_trig = wr_en && (paddr == ADCC_OFS_TRIG_SEL);
  assign rd_low  = rd_en && (paddr == ADCC_OFS_RESULT_LOW);
  assign rd_high = rd_en && (paddr == ADCC_OFS_RESULT_HIGH);
  assign mapped  = (paddr == ADCC_OFS_INPUT_SEL) || (paddr == ADCC_OFS_CTRL_STAT) ||
                   (paddr == ADCC_OFS_RESULT_LOW) || (paddr == ADCC_OFS_RESULT_HIGH) ||
                   (paddr == ADCC_OFS_TRIG_SEL);

  // start bit writes of zero are ignored
  assign sw_start = wr_ctrl && pwdata[ADCC_BIT_START];

  // trigger input crosses from outside: two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else begin
      trig_meta_ff <= trigger_in;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end

  // free running uses the done flag as its trigger, so a done edge re-launches;
  // the previous level is forced high on a switch to free running so it makes no edge
  assign trig_level = (trigger_source_select_ff == ADCC_TRIG_FREE) ? conversion_done_flag_ff
                                                                   : trig_sync_ff;
  assign trig_edge  = auto_trigger_on_ff && trig_level && !source_level_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_level_prev_ff <= 1'b0;
    end else if (wr_trig && (pwdata[7:5] == ADCC_TRIG_FREE)) begin
      source_level_prev_ff <= 1'b1;
    end else begin
      source_level_prev_ff <= trig_level;
    end
  end

  // a trigger edge while busy is dropped; the running conversion continues
  assign launch = converter_on_ff && !busy_ff && (start_req_ff || trig_edge);
  assign abort  = wr_ctrl && !pwdata[ADCC_BIT_ON];

  // start request from software held until the converter is free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_req_ff <= 1'b0;
    end else if (abort) begin
      start_req_ff <= 1'b0;
    end else if (sw_start) begin
      start_req_ff <= 1'b1;
    end else if (launch) begin
      start_req_ff <= 1'b0;
    end
  end

  adcc_prescaler u_prescaler (
    .pclk           (pclk),
    .presetn        (presetn),
    .run            (busy_ff),
    .divider_select (clock_divider_select_ff),
    .tick           (tick)
  );

  // conversion ends when the core reports done after the full cycle count
  assign finish = busy_ff && core_done && (cycle_count_ff >= cycle_target_ff);

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff          <= 1'b0;
      first_pending_ff <= 1'b1;
      cycle_count_ff   <= 5'h00;
      cycle_target_ff  <= ADCC_CYC_NORMAL;
    end else if (abort) begin
      busy_ff          <= 1'b0;
      first_pending_ff <= 1'b1;
      cycle_count_ff   <= 5'h00;
    end else if (launch) begin
      busy_ff          <= 1'b1;
      first_pending_ff <= 1'b0;
      cycle_count_ff   <= 5'h00;
      cycle_target_ff  <= first_pending_ff ? ADCC_CYC_FIRST : ADCC_CYC_NORMAL;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end else if (busy_ff && tick && (cycle_count_ff < cycle_target_ff)) begin
      cycle_count_ff <= cycle_count_ff + 5'h01;
    end
  end

  // selection is latched at completion or between conversions; an immediate relaunch would otherwise miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_select_ff <= ADCC_RST_SEL;
    end else if (finish || (!busy_ff && !launch)) begin
      active_select_ff <= channel_gain_select_ff;
    end
  end

  // channel table: decode one code into core controls
  always_comb begin
    nxt_core_req              = '0;
    nxt_core_req.start        = launch;
    nxt_core_req.gain         = ADCC_GAIN_NONE;
    if (active_select_ff <= ADCC_SEL_SE_LAST) begin
      nxt_core_req.pos_input  = active_select_ff[2:0];
    end else if (active_select_ff == ADCC_SEL_BANDGAP) begin
      nxt_core_req.bandgap    = 1'b1;
    end else if (active_select_ff == ADCC_SEL_GROUND) begin
      nxt_core_req.ground     = 1'b1;
    end else begin
      nxt_core_req.differential = 1'b1;
      if (!active_select_ff[4]) begin
        nxt_core_req.pos_input = {2'b00, active_select_ff[0]} | {1'b0, active_select_ff[2], 1'b0};
        nxt_core_req.neg_input = {1'b0, active_select_ff[2], 1'b0};
        nxt_core_req.gain      = active_select_ff[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X;
      end else begin
        nxt_core_req.pos_input = active_select_ff[2:0];
        nxt_core_req.neg_input = active_select_ff[3] ? 3'h2 : 3'h1;
        nxt_core_req.gain      = ADCC_GAIN_1X;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req_ff <= '0;
    end else begin
      core_req_ff <= nxt_core_req;
    end
  end

  assign is_diff = (active_select_ff > ADCC_SEL_SE_LAST) && (active_select_ff <= ADCC_SEL_DIFF_LAST);

  // core delivers a signed code for differential pairs; kept as is
  assign nxt_stored = core_result;

  // result register with low-then-high read lock; a low read in the finishing cycle locks already
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_ff <= ADCC_RST_RESULT;
    end else if (finish && !lock_ff && !rd_low) begin
      conversion_result_ff <= nxt_stored;
    end
  end

  // a high read unlocks; a low read in the same cycle cannot happen on apb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= 1'b0;
    end else if (rd_high) begin
      lock_ff <= 1'b0;
    end else if (rd_low) begin
      lock_ff <= 1'b1;
    end
  end

  // alignment is applied at read time so a change shows at once
  assign result_low  = left_align_select_ff ? {conversion_result_ff[1:0], 6'h00}
                                            : conversion_result_ff[7:0];
  assign result_high = left_align_select_ff ? conversion_result_ff[9:2]
                                            : {6'h00, conversion_result_ff[9:8]};

  // control and configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_ff          <= ADCC_RST_CTRL[ADCC_BIT_ON];
      auto_trigger_on_ff       <= ADCC_RST_CTRL[ADCC_BIT_AUTO];
      done_irq_enable_ff       <= ADCC_RST_CTRL[ADCC_BIT_IE];
      clock_divider_select_ff  <= ADCC_RST_CTRL[2:0];
      channel_gain_select_ff   <= ADCC_RST_SEL;
      left_align_select_ff     <= 1'b0;
      trigger_source_select_ff <= ADCC_TRIG_FREE;
    end else begin
      if (wr_ctrl) begin
        converter_on_ff         <= pwdata[ADCC_BIT_ON];
        auto_trigger_on_ff      <= pwdata[ADCC_BIT_AUTO];
        done_irq_enable_ff      <= pwdata[ADCC_BIT_IE];
        clock_divider_select_ff <= pwdata[2:0];
      end
      if (wr_sel) begin
        channel_gain_select_ff <= pwdata[4:0];
        left_align_select_ff   <= pwdata[ADCC_BIT_LEFT];
      end
      if (wr_trig) begin
        trigger_source_select_ff <= pwdata[7:5];
      end
    end
  end

  // done flag: a completion in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (finish) begin
      conversion_done_flag_ff <= 1'b1;
    end else if (irq_vector_ack || (wr_ctrl && pwdata[ADCC_BIT_DONE])) begin
      conversion_done_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_irq_ff <= 1'b0;
    end else begin
      done_irq_ff <= conversion_done_flag_ff && done_irq_enable_ff && global_irq_enable;
    end
  end

  // start reads one while busy or a launch is still pending
  assign ctrl_read = {converter_on_ff, busy_ff | start_req_ff, auto_trigger_on_ff,
                      conversion_done_flag_ff, done_irq_enable_ff, clock_divider_select_ff};

  // apb read data and ready, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      prdata_ff <= 32'h0000_0000;
      if (rd_en) begin
        case (paddr)
          ADCC_OFS_INPUT_SEL:   prdata_ff <= {26'h0, left_align_select_ff, channel_gain_select_ff};
          ADCC_OFS_CTRL_STAT:   prdata_ff <= {24'h0, ctrl_read};
          ADCC_OFS_RESULT_LOW:  prdata_ff <= {24'h0, result_low};
          ADCC_OFS_RESULT_HIGH: prdata_ff <= {24'h0, result_high};
          ADCC_OFS_TRIG_SEL:    prdata_ff <= {24'h0, trigger_source_select_ff, 5'h00};
          default:              prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // slave error raised together with ready for an unmapped address
  logic pslverr_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign done_irq = done_irq_ff;
  assign core_req = core_req_ff;

endmodule // adcc_top

// *** tb/adcc_monitor.sv ***
`timescale 1ns/10ps
module adcc_monitor
  import adcc_pkg::*;
(
  // apb side
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // interrupt side
  input wire logic           global_irq_enable,
  input wire logic           irq_vector_ack,
  input wire logic           done_irq,
  // analog core side
  input wire adcc_core_req_t core_req
);
  logic [10:0] sel_f;
  logic [7:0]  since_ff;
  // channel fields handed to the core, start left out
  assign sel_f = {core_req.pos_input, core_req.neg_input, core_req.differential,
                  core_req.bandgap, core_req.ground, core_req.gain};
  // cycles since the last launch; saturates so idle gaps cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_ff <= 8'h00;
    else if (core_req.start) since_ff <= 8'h00;
    else if (since_ff != 8'hff) since_ff <= since_ff + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without an access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_irq_global: assert property (!$past(global_irq_enable) |-> !done_irq)
    else $error("irq with global enable off");
  chk_irq_ack_clear: assert property (irq_vector_ack |-> ##2 !done_irq)
    else $error("irq stays after vector ack");
  chk_start_pulse: assert property (core_req.start |=> !core_req.start)
    else $error("core start longer than one cycle");
  chk_sel_held: assert property (core_req.start |=> $stable(sel_f) [*8])
    else $error("channel changed during conversion");
  chk_conv_length: assert property ($rose(done_irq) && $past(global_irq_enable, 2) |-> since_ff >= 8'h14)
    else $error("conversion finished too early");
endmodule // adcc_monitor

// *** tb/adcc_core_model.sv ***
`timescale 1ns/10ps
module adcc_core_model
  import adcc_pkg::*;
#(
  parameter int DELAY = 20
)
(
  // clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // request and answer
  input  wire adcc_core_req_t core_req,
  output logic                core_done,
  output logic [9:0]          core_result
);
  logic [4:0] n_ff;
  logic [9:0] res_ff;
  int         cnt;
  // answer a fixed span after each start and hold done until the next start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_ff <= 5'h00;
      cnt <= 0;
      core_done <= 1'b0;
      res_ff <= 10'h000;
    end else if (core_req.start) begin
      n_ff <= n_ff + 5'h01;
      cnt <= DELAY;
      core_done <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      core_done <= (cnt == 1);
      // pattern tracks the launch count; already in final two's complement form
      if (cnt == 1) res_ff <= {n_ff, ~n_ff};
    end
  end
  // outside the answer the bus shows no stale value
  assign core_result = core_done ? res_ff : ~res_ff;
endmodule // adcc_core_model

// *** tb/adcc_top_tb_top.sv ***
`timescale 1ns/10ps
module adcc_top_tb_top import adcc_pkg::*;;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err_v;
  logic           trigger_in, gie, ack, done_irq, core_done;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rv;
  logic [9:0]     core_result;
  logic [10:0]    cap_sel;
  logic [4:0]     c;
  adcc_core_req_t core_req;
  int             n_mismatch = 0, n_tests = 0, n_start = 0, cyc = 0, s_cyc = 0, k, n0, dv;
  initial {pclk, presetn, psel, penable, pwrite, paddr, pwdata, trigger_in, gie, ack} = '0;
  always #4 pclk = ~pclk;
  adcc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trigger_in), .global_irq_enable(gie), .irq_vector_ack(ack), .done_irq(done_irq),
    .core_req(core_req), .core_done(core_done), .core_result(core_result));
  adcc_core_model i_core (.pclk(pclk), .presetn(presetn), .core_req(core_req), .core_done(core_done),
    .core_result(core_result));
  // count launches and keep the fields the core saw
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (core_req.start === 1'b1) begin
      n_start <= n_start + 1;
      s_cyc <= cyc;
      cap_sel <= {core_req.pos_input, core_req.neg_input, core_req.differential,
                  core_req.bandgap, core_req.ground, core_req.gain};
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (done_irq !== 1'b1 && t < 4000) begin
      @(posedge pclk);
      t++;
    end
    chk(32'(t < 4000), 32'h1);
  endtask
  task automatic ack_irq();
    @(posedge pclk) ack <= 1'b1;
    @(posedge pclk) ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(done_irq, 1'b0);
  endtask
  // one launch by software, timed from the core start to the interrupt
  task automatic conv(input logic [7:0] ctl, input int n, input int d);
    k = n_start;
    apb(1'b1, ADCC_OFS_CTRL_STAT, {24'h0, ctl});
    wait_irq();
    chk(n_start - k, 32'h1);
    chk(32'((cyc - s_cyc) >= n * d - d && (cyc - s_cyc) <= n * d + d + 8), 32'h1);
  endtask
  function automatic logic [31:0] res_b(input int n, input logic left, input logic hi);
    logic [9:0] r;
    r = {n[4:0], ~n[4:0]};
    if (left) return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h00};
    return hi ? {22'h0, r[9:8]} : {24'h0, r[7:0]};
  endfunction
  // expected core fields: pos, neg, differential, bandgap, ground, gain
  function automatic logic [10:0] exp_sel(input logic [4:0] s);
    if (s <= ADCC_SEL_SE_LAST) return {s[2:0], 3'h0, 3'h0, ADCC_GAIN_NONE};
    if (s == ADCC_SEL_BANDGAP) return {6'h00, 3'h2, ADCC_GAIN_NONE};
    if (s == ADCC_SEL_GROUND) return {6'h00, 3'h1, ADCC_GAIN_NONE};
    if (!s[4]) return {1'b0, s[2], s[0], 1'b0, s[2], 1'b0, 3'h4, s[1] ? ADCC_GAIN_200X : ADCC_GAIN_10X};
    return {s[2:0], s[3] ? 3'h2 : 3'h1, 3'h4, ADCC_GAIN_1X};
  endfunction
  // fields that carry no meaning for a code are left uncompared
  function automatic logic [10:0] msk(input logic [4:0] s);
    if (s <= ADCC_SEL_SE_LAST) return 11'h71f;
    return (s >= ADCC_SEL_BANDGAP) ? 11'h01f : 11'h7ff;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    gie <= 1'b1;
    rd(ADCC_OFS_INPUT_SEL, 32'h0);
    rd(ADCC_OFS_CTRL_STAT, 32'h0);
    rd(ADCC_OFS_RESULT_LOW, 32'h0);
    rd(ADCC_OFS_RESULT_HIGH, 32'h0);
    rd(8'h20, 32'h0);
    chk(err_v, 1'b1);
    conv(8'hc8, 25, 2);
    rd(ADCC_OFS_CTRL_STAT, 32'h98);
    rd(ADCC_OFS_RESULT_LOW, res_b(n_start, 1'b0, 1'b0));
    rd(ADCC_OFS_RESULT_HIGH, res_b(n_start, 1'b0, 1'b1));
    apb(1'b1, ADCC_OFS_INPUT_SEL, 32'h20);
    rd(ADCC_OFS_RESULT_LOW, res_b(n_start, 1'b1, 1'b0));
    rd(ADCC_OFS_RESULT_HIGH, res_b(n_start, 1'b1, 1'b1));
    gie <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(done_irq, 1'b0);
    gie <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(done_irq, 1'b1);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'h88);
    rd(ADCC_OFS_CTRL_STAT, 32'h98);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'h98);
    rd(ADCC_OFS_CTRL_STAT, 32'h88);
    // every channel code, prescaler from the low bits, alignment from bit 3
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      dv = (c[2:1] == 2'h0) ? 2 : (1 << c[2:0]);
      apb(1'b1, ADCC_OFS_INPUT_SEL, {26'h0, c[3], c});
      conv({5'h19, c[2:0]}, 13, dv);
      chk(cap_sel & msk(c), exp_sel(c) & msk(c));
      rd(ADCC_OFS_RESULT_LOW, res_b(n_start, c[3], 1'b0));
      rd(ADCC_OFS_RESULT_HIGH, res_b(n_start, c[3], 1'b1));
      ack_irq();
    end
    apb(1'b1, ADCC_OFS_INPUT_SEL, 32'h0);
    n0 = n_start;
    rd(ADCC_OFS_RESULT_LOW, res_b(n0, 1'b0, 1'b0));
    conv(8'hc8, 13, 2);
    rd(ADCC_OFS_RESULT_HIGH, res_b(n0, 1'b0, 1'b1));
    ack_irq();
    apb(1'b1, ADCC_OFS_INPUT_SEL, 32'h1);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'hc8);
    repeat (4) @(posedge pclk);
    apb(1'b1, ADCC_OFS_INPUT_SEL, 32'h2);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'h08);
    repeat (100) @(posedge pclk);
    chk(done_irq, 1'b0);
    rd(ADCC_OFS_CTRL_STAT, 32'h08);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'h88);
    k = n_start;
    repeat (60) @(posedge pclk);
    chk(n_start - k, 32'h0);
    conv(8'hc8, 25, 2);
    chk(cap_sel & msk(5'h02), exp_sel(5'h02) & msk(5'h02));
    ack_irq();
    apb(1'b1, ADCC_OFS_TRIG_SEL, 32'h20);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'ha8);
    k = n_start;
    @(posedge pclk) trigger_in <= 1'b1;
    repeat (10) @(posedge pclk);
    trigger_in <= 1'b0;
    wait_irq();
    repeat (40) @(posedge pclk);
    chk(n_start - k, 32'h1);
    apb(1'b1, ADCC_OFS_TRIG_SEL, 32'h0);
    repeat (80) @(posedge pclk);
    chk(n_start - k, 32'h1);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'hb8);
    k = n_start;
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'he8);
    repeat (3) begin
      wait_irq();
      ack_irq();
    end
    chk(32'(n_start - k >= 3), 32'h1);
    apb(1'b1, ADCC_OFS_CTRL_STAT, 32'h0);
    final_report();
  end
  // watchdog well beyond the longest expected run
  initial begin
    #480000;
    n_mismatch++;
    final_report();
  end
endmodule // adcc_top_tb_top

bind adcc_top adcc_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .done_irq(done_irq), .core_req(core_req));
